// File: hw/pscmc_pkg.sv
// Register map, field layouts and timing counts of the clock-mode control.
package pscmc_pkg;

  // Register byte addresses.
  localparam logic [7:0] PSCMC_OFS_MODE = 8'h00;
  localparam logic [7:0] PSCMC_OFS_HALT = 8'h04;
  localparam logic [7:0] PSCMC_OFS_CFG = 8'h08;
  localparam logic [7:0] PSCMC_OFS_WAKE = 8'h0c;
  localparam logic [7:0] PSCMC_OFS_STAT = 8'h10;

  // Mode, HALT and configuration register field positions.
  localparam int PSCMC_B_SLOW_ON = 7;
  localparam int PSCMC_B_FAST_ON = 6;
  localparam int PSCMC_B_IT_SLOW = 5;
  localparam int PSCMC_B_CORE_SLOW = 4;
  localparam int PSCMC_B_RSVD = 3;
  localparam int PSCMC_B_HALT = 7;
  localparam int PSCMC_B_HALT_DIS = 0;
  localparam int PSCMC_B_DLY_OPT = 1;

  localparam logic [7:0] PSCMC_MODE_RST = 8'h40;

  // Legal upper nibbles, in chain order.
  localparam logic [3:0] PSCMC_N_HIGH = 4'h4;
  localparam logic [3:0] PSCMC_N_HTOD = 4'hc;
  localparam logic [3:0] PSCMC_N_DUAL = 4'he;
  localparam logic [3:0] PSCMC_N_DTOL = 4'hf;
  localparam logic [3:0] PSCMC_N_LOW = 4'hb;

  // Instruction cycle is five oscillator cycles.
  localparam int PSCMC_INST_DIV = 5;
  localparam int PSCMC_STARTUP_CYC = 256;

  localparam logic [1:0] PSCMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSCMC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic slow_osc_on;
    logic fast_osc_on;
    logic idle_timer_slow_source;
    logic core_clock_slow_select;
    logic rsvd;
    logic [2:0] idle_window_sel;
  } pscmc_mode_t;

  typedef enum logic [1:0] {
    PSCMC_HIGH_SPEED,
    PSCMC_DUAL_CLOCK,
    PSCMC_LOW_SPEED
  } pscmc_opmode_t;

  typedef struct packed {
    logic core_clk_en;
    logic fast_osc_en;
    logic slow_osc_en;
    logic core_clk_slow;
    logic idle_timer_slow;
    logic idle_timer_clk_en;
  } pscmc_clk_ctl_t;

endpackage : pscmc_pkg

// File: hw/pscmc_ctrl.sv
// Clock-mode, HALT and wake-up start-up control with an AXI4-Lite slave.
// Summary of operation
// - Reset loads the mode register with 0x40, fast oscillator on only.
// - Bit 7 switches the slow oscillator on or off.
// - Bit 6 switches the fast oscillator on or off.
// - Bit 5 picks idle timer clock: 0 fast, 1 slow.
// - Bit 4 picks core clock: 0 fast, 1 slow.
// - Bits 5:4 decode 00 high speed, 10 dual clock, 11 low speed.
// - The invalid pair 01 forces low speed mode.
// - Bits 2:0 hold the idle window selection, passed to the idle timer.
// - Upper nibble only holds 0100, 1100, 1110, 1111, 1011 in a chain.
// - A write to a non-adjacent chain state is ignored.
// - Reset enters high speed; low speed never jumps straight to it.
// - Setting the HALT bit stops the core in the next instruction cycle.
// - HALT stops the internal clock and the fast oscillator.
// - Reset low ends HALT and reinitialises every register.
// - An enabled wake-up pin transition leaves HALT.
// - Start-up delay always follows wake-up, whatever the delay option.
// - Start-up counts 256 instruction cycles, then clocks resume.
// - Instruction clock is one fifth of the fast oscillator.
// - With HALT disabled, software HALT requests are ignored.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module pscmc_ctrl
  import pscmc_pkg::*;
#(
  parameter int WAKE_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [WAKE_W-1:0] wake_pins_i,
  output pscmc_clk_ctl_t clk_ctl_o,
  output logic [2:0] idle_window_sel_o,
  output logic inst_tick_o
);

  typedef enum logic [1:0] {
    PSCMC_RUN,
    PSCMC_HALT_WAIT,
    PSCMC_HALTED,
    PSCMC_STARTUP
  } pscmc_hstate_t;

  localparam logic [8:0] STARTUP_LD = 9'(PSCMC_STARTUP_CYC);
  localparam logic [2:0] DIV_LAST = 3'(PSCMC_INST_DIV - 1);

  pscmc_mode_t mode_q;
  pscmc_hstate_t hst_q;
  pscmc_hstate_t hst_d;
  logic [8:0] su_cnt_q;
  logic [2:0] div_q;
  logic halt_dis_q;
  logic dly_opt_q;
  logic [WAKE_W-1:0] wake_en_q;
  logic [WAKE_W-1:0] wake_rise_q;
  logic [WAKE_W-1:0] w_s1_q;
  logic [WAKE_W-1:0] w_s2_q;
  logic [WAKE_W-1:0] w_s3_q;
  logic [WAKE_W-1:0] wake_edge;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Chain position of a nibble; 7 marks an illegal value.
  function automatic logic [2:0] chain_pos(input logic [3:0] n);
    case (n)
      PSCMC_N_HIGH: chain_pos = 3'h0;
      PSCMC_N_HTOD: chain_pos = 3'h1;
      PSCMC_N_DUAL: chain_pos = 3'h2;
      PSCMC_N_DTOL: chain_pos = 3'h3;
      PSCMC_N_LOW: chain_pos = 3'h4;
      default: chain_pos = 3'h7;
    endcase
  endfunction : chain_pos

  // Write channel: address and data are taken independently.
  wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take = s_axi_wvalid_i && s_axi_wready_o;
  wire aw_got = aw_hold_q || aw_take;
  wire w_got = w_hold_q || w_take;
  wire do_wr = aw_got && w_got && !bvalid_q;
  wire [7:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr_i;
  wire [31:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata_i;
  wire [3:0] wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb_i;
  wire wr_mode = do_wr && wr_addr == PSCMC_OFS_MODE && wr_strb[0];
  wire wr_halt = do_wr && wr_addr == PSCMC_OFS_HALT && wr_strb[0];
  wire wr_cfg = do_wr && wr_addr == PSCMC_OFS_CFG && wr_strb[0];
  wire wr_wake = do_wr && wr_addr == PSCMC_OFS_WAKE;
  wire wr_hit = wr_addr == PSCMC_OFS_MODE || wr_addr == PSCMC_OFS_HALT ||
    wr_addr == PSCMC_OFS_CFG || wr_addr == PSCMC_OFS_WAKE ||
    wr_addr == PSCMC_OFS_STAT;

  assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_o = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  // Mode register acceptance: same nibble or one step along the chain.
  wire [3:0] cur_nib = mode_q[7:4];
  wire [3:0] new_nib = wr_data[7:4];
  wire [2:0] cur_pos = chain_pos(cur_nib);
  wire [2:0] new_pos = chain_pos(new_nib);
  wire nib_adjacent = new_pos != 3'h7 &&
    (new_pos == cur_pos + 3'h1 || cur_pos == new_pos + 3'h1);
  wire mode_accept = new_nib == cur_nib || nib_adjacent;
  wire mode_load = wr_mode && mode_accept;
  wire halt_req = wr_halt && wr_data[PSCMC_B_HALT];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= PSCMC_RESP_OKAY;
    end else if (ce_i) begin
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? PSCMC_RESP_OKAY : PSCMC_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_hold_q <= 1'b1;
          awaddr_q <= s_axi_awaddr_i;
        end
        if (w_take) begin
          w_hold_q <= 1'b1;
          wdata_q <= s_axi_wdata_i;
          wstrb_q <= s_axi_wstrb_i;
        end
        if (bvalid_q && s_axi_bready_i) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  // Reserved bit is stored as zero whatever software writes.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= PSCMC_MODE_RST;
    end else if (ce_i && mode_load) begin
      mode_q <= {wr_data[7:4], 1'b0, wr_data[2:0]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      halt_dis_q <= 1'b0;
      dly_opt_q <= 1'b0;
      wake_en_q <= '0;
      wake_rise_q <= '0;
    end else if (ce_i) begin
      if (wr_cfg) begin
        halt_dis_q <= wr_data[PSCMC_B_HALT_DIS];
        dly_opt_q <= wr_data[PSCMC_B_DLY_OPT];
      end
      if (wr_wake) begin
        wake_en_q <= wr_data[WAKE_W-1:0];
        wake_rise_q <= wr_data[WAKE_W+15:16];
      end
    end
  end

  // Wake-up pins: two flops, then edge detection on the settled copy.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      w_s1_q <= '0;
      w_s2_q <= '0;
      w_s3_q <= '0;
    end else if (ce_i) begin
      w_s1_q <= wake_pins_i;
      w_s2_q <= w_s1_q;
      w_s3_q <= w_s2_q;
    end
  end

  for (genvar i = 0; i < WAKE_W; i++) begin : g_wake
    assign wake_edge[i] = wake_en_q[i] && (wake_rise_q[i] ?
      (w_s2_q[i] && !w_s3_q[i]) : (!w_s2_q[i] && w_s3_q[i]));
  end

  wire wake_hit = |wake_edge;

  // The divider stands still in HALT, as the oscillator does.
  wire inst_tick = hst_q != PSCMC_HALTED && div_q == DIV_LAST;
  assign inst_tick_o = inst_tick;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 3'h0;
    end else if (ce_i && hst_q != PSCMC_HALTED) begin
      div_q <= inst_tick ? 3'h0 : div_q + 3'h1;
    end
  end

  wire su_done = hst_q == PSCMC_STARTUP && inst_tick && su_cnt_q == 9'h1;

  // The delay option is kept for software but never skips start-up.
  always_comb begin
    hst_d = hst_q;
    case (hst_q)
      PSCMC_RUN: begin
        if (halt_req && !halt_dis_q) begin
          hst_d = PSCMC_HALT_WAIT;
        end
      end
      PSCMC_HALT_WAIT: begin
        if (inst_tick) begin
          hst_d = PSCMC_HALTED;
        end
      end
      PSCMC_HALTED: begin
        if (wake_hit) begin
          hst_d = PSCMC_STARTUP;
        end
      end
      PSCMC_STARTUP: begin
        if (su_done) begin
          hst_d = PSCMC_RUN;
        end
      end
      default: hst_d = PSCMC_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hst_q <= PSCMC_RUN;
      su_cnt_q <= 9'h0;
    end else if (ce_i) begin
      hst_q <= hst_d;
      if (hst_q == PSCMC_HALTED && wake_hit) begin
        su_cnt_q <= STARTUP_LD;
      end else if (hst_q == PSCMC_STARTUP && inst_tick) begin
        su_cnt_q <= su_cnt_q - 9'h1;
      end
    end
  end

  // Invalid 01 pair is shown as low speed.
  wire core_slow = mode_q.core_clock_slow_select;
  wire it_slow = mode_q.idle_timer_slow_source || core_slow;
  pscmc_opmode_t opmode;
  assign opmode = core_slow ? PSCMC_LOW_SPEED :
    (it_slow ? PSCMC_DUAL_CLOCK : PSCMC_HIGH_SPEED);
  wire halted = hst_q == PSCMC_HALTED;
  wire core_run = hst_q == PSCMC_RUN || hst_q == PSCMC_HALT_WAIT;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_ctl_o <= '0;
      idle_window_sel_o <= 3'h0;
    end else if (ce_i) begin
      clk_ctl_o.core_clk_en <= core_run;
      clk_ctl_o.fast_osc_en <= mode_q.fast_osc_on && !halted;
      clk_ctl_o.slow_osc_en <= mode_q.slow_osc_on;
      clk_ctl_o.core_clk_slow <= core_slow;
      // Start-up is timed on the fast clock, whatever the mode says.
      clk_ctl_o.idle_timer_slow <= it_slow && hst_q != PSCMC_STARTUP;
      clk_ctl_o.idle_timer_clk_en <= !halted;
      idle_window_sel_o <= mode_q.idle_window_sel;
    end
  end

  // Read channel: one outstanding read, answered the cycle after it is taken.
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
  wire [31:0] stat_word = {27'h0, 3'(opmode), hst_q == PSCMC_STARTUP, halted};
  wire [31:0] rd_word =
    s_axi_araddr_i == PSCMC_OFS_MODE ? {24'h0, mode_q} :
    s_axi_araddr_i == PSCMC_OFS_HALT ? {24'h0, !core_run, 7'h0} :
    s_axi_araddr_i == PSCMC_OFS_CFG ? {30'h0, dly_opt_q, halt_dis_q} :
    s_axi_araddr_i == PSCMC_OFS_WAKE ?
      32'({wake_rise_q, 16'(wake_en_q)}) :
    s_axi_araddr_i == PSCMC_OFS_STAT ? stat_word : 32'h0;
  wire rd_hit = s_axi_araddr_i == PSCMC_OFS_MODE ||
    s_axi_araddr_i == PSCMC_OFS_HALT || s_axi_araddr_i == PSCMC_OFS_CFG ||
    s_axi_araddr_i == PSCMC_OFS_WAKE || s_axi_araddr_i == PSCMC_OFS_STAT;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= PSCMC_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? PSCMC_RESP_OKAY : PSCMC_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Helper: instruction ticks spent in start-up.
  logic [9:0] su_ticks_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      su_ticks_q <= 10'h0;
    end else if (ce_i) begin
      if (hst_q != PSCMC_STARTUP) begin
        su_ticks_q <= 10'h0;
      end else if (inst_tick) begin
        su_ticks_q <= su_ticks_q + 10'h1;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i || !ce_i);

  sequence s_halt_req;
    hst_q == PSCMC_RUN && halt_req && !halt_dis_q;
  endsequence
  sequence s_halt_in;
    ##[1:6] hst_q == PSCMC_HALTED;
  endsequence

  a_mode_chain_legal: assert property (
    chain_pos(mode_q[7:4]) != 3'h7 && !mode_q.rsvd)
    else $error("mode register upper nibble left the legal chain");
  a_reject_keeps: assert property (
    wr_mode && !mode_accept |=> $stable(mode_q))
    else $error("rejected mode write changed the register");
  a_accept_loads: assert property (
    mode_load |=> mode_q[7:4] == $past(wr_data[7:4]) &&
      mode_q[2:0] == $past(wr_data[2:0]))
    else $error("accepted mode write not stored");
  a_low_no_jump: assert property (
    mode_q[7:4] == PSCMC_N_LOW |=> mode_q[7:4] != PSCMC_N_HIGH)
    else $error("low speed jumped straight to high speed");
  a_halt_entry: assert property (
    s_halt_req |-> s_halt_in)
    else $error("halt not reached within one instruction cycle");
  a_halt_disabled: assert property (
    hst_q == PSCMC_RUN && halt_dis_q |=> hst_q == PSCMC_RUN)
    else $error("halt entered although disabled");
  a_fast_osc_off: assert property (
    halted ##1 halted |-> !clk_ctl_o.fast_osc_en && !clk_ctl_o.core_clk_en)
    else $error("fast oscillator or core clock left on in halt");
  a_wake_startup: assert property (
    halted && wake_hit |=> hst_q == PSCMC_STARTUP && su_cnt_q == STARTUP_LD)
    else $error("wake-up did not start the start-up delay");
  a_startup_len: assert property (
    hst_q == PSCMC_STARTUP && $past(hst_q) == PSCMC_STARTUP &&
      hst_d == PSCMC_RUN |-> su_ticks_q == 10'd255)
    else $error("start-up delay not 256 instruction cycles");
  a_invalid_slow: assert property (
    core_slow |-> opmode == PSCMC_LOW_SPEED && it_slow)
    else $error("invalid clock pair not forced to low speed");
  a_tick_period: assert property (
    inst_tick && hst_q != PSCMC_HALT_WAIT |=> !inst_tick [*4])
    else $error("instruction tick faster than one in five");

endmodule : pscmc_ctrl

// File: bench/test_power_save_clock_mode_control.sv
// Self-checking testbench of the clock-mode, HALT and wake-up control.
`timescale 1ns/100ps
module test_power_save_clock_mode_control;
  import pscmc_pkg::*;
  logic ref_clk_i;
  logic rst_b_i;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, tick;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [7:0] wake;
  pscmc_clk_ctl_t ctl;
  logic [2:0] win;
  int error_cnt, cmp_count, cyc, n;
  logic [31:0] rd;
  logic [1:0] rs;
  // Each row is the byte written to the mode register, then its expected
  // value.
  // Rows walk the chain both ways and try jumps that must leave it unchanged.
  logic [15:0] rows [12] = '{16'h4545, 16'he045, 16'hc0c0, 16'he3e3,
    16'hf0f0, 16'hb0b0, 16'hc0b0, 16'h40b0, 16'hf0f0, 16'he0e0,
    16'hc0c0, 16'h4040};

  pscmc_ctrl i_pscmc_ctrl (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(1'b1),
    .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .wake_pins_i(wake),
    .clk_ctl_o(ctl),
    .idle_window_sel_o(win),
    .inst_tick_o(tick)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Ready signals for the responses stay high, so a task never lowers and
  // raises them in one time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk_i);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (bvalid !== 1'b1);
    rs = bresp;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk_i); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask : rd_reg

  task automatic wait_core(input logic v, input int lim);
    n = 0;
    while (ctl.core_clk_en !== v && n < lim) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask : wait_core

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    rst_b_i = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    wake = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk("clk_ctl", ctl, 6'h31);
    rd_reg(PSCMC_OFS_MODE);
    chk("mode", rd, 32'h40);
    foreach (rows[i]) begin
      wr(PSCMC_OFS_MODE, {24'h0, rows[i][15:8]}, 4'hf);
      rd_reg(PSCMC_OFS_MODE);
      chk("mode", rd, {24'h0, rows[i][7:0]});
      chk("window", win, rows[i][2:0]);
      chk("osc_on", {ctl.slow_osc_en, ctl.fast_osc_en},
          rows[i][7:6]);
      chk("clk_sel", {ctl.idle_timer_slow, ctl.core_clk_slow},
          rows[i][5:4]);
      rd_reg(PSCMC_OFS_STAT);
      chk("opmode", rd[4:2], rows[i][5:4] == 2'h0 ? 3'h0 :
          rows[i][5:4] == 2'h2 ? 3'h1 : 3'h2);
    end
    rd_reg(8'h14);
    chk("rd_resp", rs, PSCMC_RESP_SLVERR);
    chk("rd_data", rd, 32'h0);
    wr(8'h14, 32'hff, 4'hf);
    chk("wr_resp", rs, PSCMC_RESP_SLVERR);
    wr(PSCMC_OFS_MODE, 32'hc0, 4'h0);
    rd_reg(PSCMC_OFS_MODE);
    chk("mode", rd, 32'h40);
    // HALT requests must be ignored while the disable option is set.
    wr(PSCMC_OFS_CFG, 32'h1, 4'hf);
    wr(PSCMC_OFS_HALT, 32'h80, 4'hf);
    repeat (20) @(posedge ref_clk_i);
    chk("halt_off", ctl.core_clk_en, 1'b1);
    // The delay option is set here, yet the start-up delay must still run.
    wr(PSCMC_OFS_CFG, 32'h2, 4'hf);
    wr(PSCMC_OFS_WAKE, 32'h0001_0001, 4'hf);
    wr(PSCMC_OFS_HALT, 32'h80, 4'hf);
    wait_core(1'b0, 12);
    chk("halted", ctl.core_clk_en, 1'b0);
    chk("fast_osc", ctl.fast_osc_en, 1'b0);
    n = 0;
    repeat (20) begin
      @(posedge ref_clk_i);
      if (tick === 1'b1) begin
        n++;
      end
    end
    chk("halt_ticks", n, 0);
    rd_reg(PSCMC_OFS_STAT);
    chk("stat_halt", rd[0], 1'b1);
    wake <= 8'h01;
    wait_core(1'b1, 2000);
    chk("startup", n >= 1280 && n <= 1300, 1'b1);
    do @(posedge ref_clk_i); while (tick !== 1'b1);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (tick !== 1'b1);
    chk("tick_period", n, 5);
    wake <= 8'h00;
    wr(PSCMC_OFS_MODE, 32'hc0, 4'hf);
    wr(PSCMC_OFS_HALT, 32'h80, 4'hf);
    wait_core(1'b0, 12);
    chk("halted", ctl.core_clk_en, 1'b0);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk("reset_run", ctl.core_clk_en, 1'b1);
    rd_reg(PSCMC_OFS_MODE);
    chk("mode", rd, 32'h40);
    rd_reg(PSCMC_OFS_STAT);
    chk("stat", rd[4:0], 5'h0);
    final_report();
  end
endmodule : test_power_save_clock_mode_control
